// ### logic/ssc_regs.vh
// register offsets, field positions and reset values of the sync controller
// assumes a 32-bit classic wishbone slave with word addressing by byte
`ifndef SSC_REGS_VH
`define SSC_REGS_VH
`define SSC_CTRL_OFS 8'h00
`define SSC_CPC_OFS 8'h04
`define SSC_FNOM_OFS 8'h08
`define SSC_FDEV_OFS 8'h0C
`define SSC_TWIN_OFS 8'h10
`define SSC_STAT_OFS 8'h14
`define SSC_MCPC_OFS 8'h18
`define SSC_MPER_OFS 8'h1C
`define SSC_ERR_OFS 8'h20
`define SSC_DEG_OFS 8'h24
// control fields
`define SSC_CTRL_SRC_LSB 0
`define SSC_CTRL_ZONLY_BIT 2
`define SSC_CTRL_MODE_LSB 4
`define SSC_CTRL_START_BIT 8
`define SSC_CTRL_STOP_BIT 9
// error flag positions
`define SSC_ERR_CPC_BIT 0
`define SSC_ERR_FREQ_BIT 1
// reset values
`define SSC_CTRL_RST 32'h00000030
`define SSC_CPC_RST 32'h00000100
`define SSC_FNOM_RST 32'h00004E20
`define SSC_FDEV_RST 32'h00000200
`define SSC_TWIN_RST 32'h00000064
`endif

// ### logic/ssc_sync_ctrl.v
// sequence synchronisation controller: source select, lock, start, checks
// assumes async pins sampled on MCLK_I and a classic wishbone master
// What this block does
// - software picks generator a, b or mains; generators use clock+index or index
// - clock+index: count clocks between index pulses, lock timer to clock
// - clock+index while running: no checks run, index pulses are not cycle boundaries
// - clock+index: first clock rise after index rise marks zero degrees
// - index only: lock to index, rise is zero degrees, keep checking in full mode and within the timed window
// - mains: each detected zero crossing acts exactly like an index pulse
// - full, timed and measured modes start the sequence at an index pulse
// - full mode checks timing against the source for the whole sequence with index only or mains
// - timed mode checks only within a software interval after start
// - after the timed interval, stop checking and keep last measured values
// - measured mode locks before start, then runs on last measured values
// - mode none uses software parameters and ignores every source
// - mode none starts at once on a start command
// - clock+index: measured clocks per cycle differing from setting is an error
// - frequency outside nominal plus or minus deviation is an error
// - programmed frequency sets mode none degree timing and the frequency limits
// - locking begins after start command; timing follows source while running in full mode and within the timed window
//
// Implementation choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ns
`include "ssc_regs.vh"
module ssc_sync_ctrl #(
  parameter CLK_HZ = 250000000,
  parameter SYS_TICKS_PER_MS = 250000
) (
  input wire MCLK_I,
  input wire NRST_I,
  input wire GEN_A_CLOCK_IN_I,
  input wire GEN_B_CLOCK_IN_I,
  input wire GEN_A_INDEX_IN_I,
  input wire GEN_B_INDEX_IN_I,
  input wire MAINS_SIGN_I,
  input wire [7:0] WB_ADR_I,
  input wire [31:0] WB_DAT_I,
  output reg [31:0] WB_DAT_O,
  input wire [3:0] WB_SEL_I,
  input wire WB_WE_I,
  input wire WB_CYC_I,
  input wire WB_STB_I,
  output reg WB_ACK_O,
  output reg RUNNING_O,
  output reg ZERO_DEG_O,
  output reg SYNC_ERR_O
);
  localparam MODE_FULL = 2'h0;
  localparam MODE_TIMED = 2'h1;
  localparam MODE_MEAS = 2'h2;
  localparam MODE_NONE = 2'h3;
  localparam ST_IDLE = 2'h0;
  localparam ST_LOCK = 2'h1;
  localparam ST_ARM = 2'h2;
  localparam ST_RUN = 2'h3;
  reg rst_a_q;
  reg rst_b_q;
  wire rst_n = rst_b_q;
  // reset released through two flops, asserted at once
  always @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rst_a_q <= 1'b0;
      rst_b_q <= 1'b0;
    end else begin
      rst_a_q <= 1'b1;
      rst_b_q <= rst_a_q;
    end
  end
  // three-flop synchronisers; a level counts once stages two and three agree
  reg [2:0] s0_q, s1_q, s2_q, s3_q, s4_q;
  reg [4:0] lvl_q;
  wire [4:0] agree = ~(({s4_q[1],s3_q[1],s2_q[1],s1_q[1],s0_q[1]}) ^
                       ({s4_q[2],s3_q[2],s2_q[2],s1_q[2],s0_q[2]}));
  wire [4:0] newv = {s4_q[2],s3_q[2],s2_q[2],s1_q[2],s0_q[2]};
  always @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      s0_q <= 3'h0;
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      s3_q <= 3'h0;
      s4_q <= 3'h0;
      lvl_q <= 5'h00;
    end else begin
      s0_q <= {s0_q[1:0], GEN_A_CLOCK_IN_I};
      s1_q <= {s1_q[1:0], GEN_B_CLOCK_IN_I};
      s2_q <= {s2_q[1:0], GEN_A_INDEX_IN_I};
      s3_q <= {s3_q[1:0], GEN_B_INDEX_IN_I};
      s4_q <= {s4_q[1:0], MAINS_SIGN_I};
      lvl_q <= (agree & newv) | (~agree & lvl_q);
    end
  end
  wire [4:0] nxt_lvl = (agree & newv) | (~agree & lvl_q);
  wire [4:0] rise = nxt_lvl & ~lvl_q;
  wire [4:0] chg = nxt_lvl ^ lvl_q;
  // registers
  reg [31:0] ctrl_q, cpc_q, fnom_q, fdev_q, twin_q;
  reg [1:0] err_q;
  wire [1:0] src = ctrl_q[`SSC_CTRL_SRC_LSB+1:`SSC_CTRL_SRC_LSB];
  wire zonly = ctrl_q[`SSC_CTRL_ZONLY_BIT];
  wire [1:0] mode = ctrl_q[`SSC_CTRL_MODE_LSB+1:`SSC_CTRL_MODE_LSB];
  // mains on source 2 always behaves as index only, each crossing is an index pulse
  wire use_clk = (src != 2'h2) && !zonly;
  reg clk_rise, idx_rise;
  // source selection
  always @* begin
    clk_rise = 1'b0;
    idx_rise = 1'b0;
    case (src)
      2'h0: begin
        clk_rise = rise[0];
        idx_rise = rise[2];
      end
      2'h1: begin
        clk_rise = rise[1];
        idx_rise = rise[3];
      end
      default: begin
        idx_rise = chg[4]; // both crossings, as index pulses
      end
    endcase
  end
  reg [1:0] st_q;
  reg [31:0] per_cnt_q, mper_q, clk_cnt_q, mcpc_q, win_cnt_q;
  reg [31:0] deg_cnt_q, deg_q;
  reg idx_seen_q, have_per_q, checking_q, last_bad_q;
  wire acc = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  // writes land at the edge where the master sees ack, not a cycle early
  wire wr = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O;
  // a start takes the mode written with it, not the one stored before
  wire [1:0] start_mode = WB_DAT_I[`SSC_CTRL_MODE_LSB+1:`SSC_CTRL_MODE_LSB];
  wire start_cmd = wr && (WB_ADR_I == `SSC_CTRL_OFS) && WB_SEL_I[1] &&
                   WB_DAT_I[`SSC_CTRL_START_BIT];
  wire stop_cmd = wr && (WB_ADR_I == `SSC_CTRL_OFS) && WB_SEL_I[1] &&
                  WB_DAT_I[`SSC_CTRL_STOP_BIT];
  // zero reference: clock after index, or the index itself
  wire zero_evt = use_clk ? (clk_rise && idx_seen_q) : idx_rise;
  // period of one cycle, in system ticks, of the programmed frequency (mHz)
  wire [63:0] nom_per = (64'd1000 * CLK_HZ) / (fnom_q == 32'h0 ? 64'd1 :
                        {32'h0, fnom_q});
  wire [31:0] fhi = fnom_q + fdev_q;
  wire [31:0] flo = (fnom_q > fdev_q) ? fnom_q - fdev_q : 32'h0;
  // measured frequency in mHz from the measured period
  wire [63:0] mfreq = (64'd1000 * CLK_HZ) / (per_cnt_q == 32'h0 ? 64'd1 :
                      {32'h0, per_cnt_q});
  wire freq_bad = ({32'h0, flo} > mfreq) || (mfreq > {32'h0, fhi});
  wire cpc_bad = use_clk && (clk_cnt_q != cpc_q);
  wire [31:0] per_use = (mode == MODE_NONE) ? nom_per[31:0] : mper_q;
  wire win_open = win_cnt_q < twin_q * SYS_TICKS_PER_MS;
  // checking stays on in full, windowed in timed, off in measured
  wire chk_run = (mode == MODE_FULL) ||
                 ((mode == MODE_TIMED) && win_open);
  // cycle boundary used for measuring: index in clock mode only before running (lock and arm)
  wire meas_evt = (use_clk && (st_q == ST_RUN)) ? 1'b0 : idx_rise;
  // check results at one cycle boundary while checking is on
  wire err_chk = checking_q && meas_evt && have_per_q && (mode != MODE_NONE);
  wire err_wr = wr && (WB_ADR_I == `SSC_ERR_OFS) && WB_SEL_I[0];
  wire [1:0] err_clr = err_wr ? WB_DAT_I[1:0] : 2'h0;
  reg [1:0] err_set;
  always @* begin
    err_set = 2'h0;
    if (err_chk) begin
      err_set[`SSC_ERR_CPC_BIT] = cpc_bad;
      err_set[`SSC_ERR_FREQ_BIT] = freq_bad;
    end
  end
  // a new error in the clearing cycle wins over the clear
  wire [1:0] err_nxt = (err_q & ~err_clr) | err_set;
  // sequencer state, measurement and checks
  always @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      per_cnt_q <= 32'h0;
      mper_q <= 32'h0;
      clk_cnt_q <= 32'h0;
      mcpc_q <= 32'h0;
      win_cnt_q <= 32'h0;
      deg_cnt_q <= 32'h0;
      deg_q <= 32'h0;
      idx_seen_q <= 1'b0;
      have_per_q <= 1'b0;
      checking_q <= 1'b0;
      last_bad_q <= 1'b0;
      RUNNING_O <= 1'b0;
      ZERO_DEG_O <= 1'b0;
      err_q <= 2'h0;
      SYNC_ERR_O <= 1'b0;
    end else begin
      ZERO_DEG_O <= 1'b0;
      if (idx_rise)
        idx_seen_q <= 1'b1;
      else if (clk_rise)
        idx_seen_q <= 1'b0;
      // cycle measurement follows the source on the fly
      if (st_q != ST_IDLE && mode != MODE_NONE) begin
        per_cnt_q <= per_cnt_q + 32'h1;
        if (clk_rise && use_clk)
          clk_cnt_q <= clk_cnt_q + 32'h1;
        if (meas_evt) begin
          per_cnt_q <= 32'h1;
          clk_cnt_q <= 32'h0;
          have_per_q <= 1'b1;
          // judged on a whole cycle; the live counts are partial later on
          last_bad_q <= freq_bad || cpc_bad;
          if (st_q != ST_RUN || chk_run) begin
            mper_q <= per_cnt_q; // last measured value kept after
            mcpc_q <= clk_cnt_q;
          end
        end
      end
      // internal degree timer, re-aligned at each zero in full mode and within the timed window
      if (st_q == ST_RUN) begin
        if (zero_evt && (mode == MODE_FULL || chk_run)) begin
          deg_cnt_q <= 32'h0;
          ZERO_DEG_O <= 1'b1;
        end else if (deg_cnt_q + 32'h1 >= per_use) begin
          deg_cnt_q <= 32'h0;
          ZERO_DEG_O <= 1'b1;
        end else begin
          deg_cnt_q <= deg_cnt_q + 32'h1;
        end
        deg_q <= deg_cnt_q;
        win_cnt_q <= win_cnt_q + 32'h1;
      end
      checking_q <= (st_q == ST_LOCK) || (st_q == ST_ARM) ||
                    ((st_q == ST_RUN) && chk_run);
      case (st_q)
        ST_IDLE: begin
          if (start_cmd) begin
            win_cnt_q <= 32'h0;
            have_per_q <= 1'b0;
            deg_cnt_q <= 32'h0;
            if (start_mode == MODE_NONE) begin
              st_q <= ST_RUN;
              RUNNING_O <= 1'b1;
              ZERO_DEG_O <= 1'b1;
            end else begin
              st_q <= ST_LOCK;
            end
          end
        end
        ST_LOCK: begin
          if (have_per_q && meas_evt)
            st_q <= ST_ARM;
        end
        ST_ARM: begin
          // start on the zero reference of the source
          if (zero_evt && !last_bad_q) begin
            st_q <= ST_RUN;
            RUNNING_O <= 1'b1;
            ZERO_DEG_O <= 1'b1;
          end
        end
        default: begin
          // clock mode while running has no cycle boundary, so no clock count check runs
        end
      endcase
      if (stop_cmd) begin
        st_q <= ST_IDLE;
        RUNNING_O <= 1'b0;
      end
      // sticky errors, held until software writes ones back
      err_q <= err_nxt;
      SYNC_ERR_O <= |err_nxt;
    end
  end
  // wishbone slave: ack one cycle after the request, unmapped reads give zero
  always @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0;
      ctrl_q <= `SSC_CTRL_RST;
      cpc_q <= `SSC_CPC_RST;
      fnom_q <= `SSC_FNOM_RST;
      fdev_q <= `SSC_FDEV_RST;
      twin_q <= `SSC_TWIN_RST;
    end else begin
      WB_ACK_O <= acc;
      if (wr) begin
        if (WB_ADR_I == `SSC_CTRL_OFS)
          ctrl_q <= {22'h0, 2'h0, WB_DAT_I[7:0]};
        else if (WB_ADR_I == `SSC_CPC_OFS)
          cpc_q <= WB_DAT_I;
        else if (WB_ADR_I == `SSC_FNOM_OFS)
          fnom_q <= WB_DAT_I;
        else if (WB_ADR_I == `SSC_FDEV_OFS)
          fdev_q <= WB_DAT_I;
        else if (WB_ADR_I == `SSC_TWIN_OFS)
          twin_q <= WB_DAT_I;
      end
      if (WB_ADR_I == `SSC_CTRL_OFS)
        WB_DAT_O <= ctrl_q;
      else if (WB_ADR_I == `SSC_CPC_OFS)
        WB_DAT_O <= cpc_q;
      else if (WB_ADR_I == `SSC_FNOM_OFS)
        WB_DAT_O <= fnom_q;
      else if (WB_ADR_I == `SSC_FDEV_OFS)
        WB_DAT_O <= fdev_q;
      else if (WB_ADR_I == `SSC_TWIN_OFS)
        WB_DAT_O <= twin_q;
      else if (WB_ADR_I == `SSC_STAT_OFS)
        WB_DAT_O <= {27'h0, checking_q, RUNNING_O, 1'b0, st_q};
      else if (WB_ADR_I == `SSC_MCPC_OFS)
        WB_DAT_O <= mcpc_q;
      else if (WB_ADR_I == `SSC_MPER_OFS)
        WB_DAT_O <= mper_q;
      else if (WB_ADR_I == `SSC_ERR_OFS)
        WB_DAT_O <= {30'h0, err_q};
      else if (WB_ADR_I == `SSC_DEG_OFS)
        WB_DAT_O <= deg_q;
      else
        WB_DAT_O <= 32'h0;
    end
  end
endmodule

// ### verification/ssc_gen_model.sv
// behavioural generator: free running clock plus a zero index pulse
// assumes the controller samples these pins asynchronously on its clock
`timescale 1ns/1ns
module ssc_gen_model #(
  parameter int CPI = 8,
  parameter int HALF = 24
) (
  output logic clk_o,
  output logic idx_o,
  output logic sgn_o
);
  // index rises on a clock fall so the next clock rise is zero degrees
  initial begin
    clk_o = 1'b0;
    idx_o = 1'b0;
    sgn_o = 1'b0;
    forever begin
      for (int k = 0; k < CPI; k++) begin
        #HALF clk_o = 1'b1;
        #HALF clk_o = 1'b0;
        idx_o = (k == CPI - 1);
        if (k == CPI - 1) sgn_o = ~sgn_o; // mains sign flips per index
      end
    end
  end
endmodule

// ### verification/ssc_sync_ctrl_assertions.sv
// checker of bus answers and output levels of the sync controller
// assumes it is bound to the controller and sees only its ports
`timescale 1ns/1ns
module ssc_sync_ctrl_chk (
  input wire MCLK_I,
  input wire NRST_I,
  input wire [7:0] WB_ADR_I,
  input wire [31:0] WB_DAT_I,
  input wire [3:0] WB_SEL_I,
  input wire WB_WE_I,
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_ACK_O,
  input wire [31:0] WB_DAT_O,
  input wire RUNNING_O,
  input wire ZERO_DEG_O,
  input wire SYNC_ERR_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!NRST_I);
  // request decode; the whole held request counts, not only the ack edge
  wire req = WB_CYC_I && WB_STB_I;
  wire ctl = req && WB_WE_I && WB_ADR_I == 8'h00 && WB_SEL_I[1];
  wire start_req = ctl && WB_DAT_I[8];
  wire stop_req = ctl && WB_DAT_I[9];
  wire clr_req = req && WB_WE_I && WB_ADR_I == 8'h20 && WB_SEL_I[0];
  reg seen_q;
  // remembers a start since the last stop, a stop wins
  always @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) seen_q <= 1'b0;
    else if (stop_req) seen_q <= 1'b0;
    else if (start_req) seen_q <= 1'b1;
  end
  property p_ack_next; req && !WB_ACK_O |=> WB_ACK_O; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_one; WB_ACK_O |=> !WB_ACK_O; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack long");
  property p_ack_cause; WB_ACK_O |-> $past(req) && req; endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
  property p_unmapped;
    WB_ACK_O && !WB_WE_I && WB_ADR_I > 8'h24 |-> WB_DAT_O == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("hole read");
  property p_zero_pulse; ZERO_DEG_O |=> !ZERO_DEG_O; endproperty
  a_zero_pulse: assert property (p_zero_pulse) else $error("zero long");
  property p_run_hold;
    RUNNING_O && !stop_req && !$past(stop_req) |=> RUNNING_O;
  endproperty
  a_run_hold: assert property (p_run_hold) else $error("run lost");
  property p_run_cause; $rose(RUNNING_O) |-> seen_q; endproperty
  a_run_cause: assert property (p_run_cause) else $error("run alone");
  property p_err_hold;
    SYNC_ERR_O && !clr_req && !$past(clr_req) |=> SYNC_ERR_O;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("err lost");
  // main scenarios reached
  c_run: cover property ($rose(RUNNING_O));
  c_err: cover property ($rose(SYNC_ERR_O));
  c_zero: cover property (ZERO_DEG_O && RUNNING_O);
endmodule
bind ssc_sync_ctrl ssc_sync_ctrl_chk ssc_sync_ctrl_chk_i (.MCLK_I(MCLK_I),
  .NRST_I(NRST_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I),
  .WB_SEL_I(WB_SEL_I), .WB_WE_I(WB_WE_I), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .WB_DAT_O(WB_DAT_O),
  .RUNNING_O(RUNNING_O), .ZERO_DEG_O(ZERO_DEG_O), .SYNC_ERR_O(SYNC_ERR_O));

// ### verification/ssc_sync_ctrl_test.sv
// bench of the sync controller: register access, sources, modes, errors
// assumes generator models free running; ms scaled to 10 ticks
`timescale 1ns/1ns
module ssc_sync_ctrl_test;
  logic MCLK_I = 1'b0;
  logic NRST_I = 1'b0;
  logic WB_WE_I = 1'b0;
  logic WB_CYC_I = 1'b0;
  logic WB_STB_I = 1'b0;
  logic [7:0] WB_ADR_I = 8'h00;
  logic [31:0] WB_DAT_I = 32'h00000000;
  logic [3:0] WB_SEL_I = 4'h0;
  logic [31:0] q;
  wire [31:0] WB_DAT_O;
  wire WB_ACK_O, RUNNING_O, ZERO_DEG_O, SYNC_ERR_O;
  wire a_clk, a_idx, b_clk, b_idx, b_sgn;
  int failures = 0;
  int comparisons = 0;
  int n;
  logic [7:0] ofs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h30};
  logic [31:0] rv [6] = '{32'h30, 32'h100, 32'h4E20, 32'h200, 32'h64, 32'h0};
  always #2 MCLK_I = ~MCLK_I;
  ssc_gen_model #(.HALF(24)) gen_a_i (.clk_o(a_clk), .idx_o(a_idx),
    .sgn_o());
  ssc_gen_model #(.CPI(16), .HALF(24)) gen_b_i (.clk_o(b_clk), .idx_o(b_idx),
    .sgn_o(b_sgn));
  ssc_sync_ctrl #(.SYS_TICKS_PER_MS(10)) ssc_sync_ctrl_i (.MCLK_I(MCLK_I),
    .NRST_I(NRST_I), .GEN_A_CLOCK_IN_I(a_clk), .GEN_B_CLOCK_IN_I(b_clk),
    .GEN_A_INDEX_IN_I(a_idx), .GEN_B_INDEX_IN_I(b_idx),
    .MAINS_SIGN_I(b_sgn), .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I),
    .WB_DAT_O(WB_DAT_O), .WB_SEL_I(WB_SEL_I), .WB_WE_I(WB_WE_I),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O),
    .RUNNING_O(RUNNING_O), .ZERO_DEG_O(ZERO_DEG_O), .SYNC_ERR_O(SYNC_ERR_O));
  task close_out;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  // one classic cycle; read data taken at the ack edge, then one idle
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= we;
    WB_ADR_I <= a;
    WB_DAT_I <= d;
    WB_SEL_I <= 4'hF;
    do begin
      @(posedge MCLK_I);
      k++;
    end while (WB_ACK_O !== 1'b1 && k < 20);
    q = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    if (WB_ACK_O !== 1'b1) begin
      failures++;
      close_out();
    end
    @(posedge MCLK_I);
  endtask
  // bounded wait for running (0) or error (1) to go high
  task wait_hi(input int which, input int lim);
    int k;
    for (k = 0; k < lim; k++) begin
      @(posedge MCLK_I);
      if ((which ? SYNC_ERR_O : RUNNING_O) === 1'b1) break;
    end
    if (k == lim) begin
      failures++;
      close_out();
    end
  endtask
  initial begin
    repeat (2) @(posedge MCLK_I);
    NRST_I <= 1'b1;
    repeat (3) @(posedge MCLK_I);
    wb(1'b1, 8'h30, 32'hFFFFFFFF);
    foreach (ofs[k]) begin
      wb(1'b0, ofs[k], 32'h0);
      chk(q, rv[k]);
    end
    wb(1'b1, 8'h04, 32'h8);
    wb(1'b1, 8'h08, 32'h59682F00);
    wb(1'b1, 8'h0C, 32'h47868C00);
    wb(1'b1, 8'h10, 32'h14);
    // mode none: 1.5 MHz nominal on a 250 MHz clock is a 166 tick cycle
    wb(1'b1, 8'h00, 32'h130);
    wait_hi(0, 10);
    chk(RUNNING_O, 1'b1);
    n = 0;
    repeat (332) begin
      @(posedge MCLK_I);
      if (ZERO_DEG_O === 1'b1) n++;
    end
    chk(n, 2);
    wb(1'b1, 8'h00, 32'h230);
    chk(RUNNING_O, 1'b0);
    // index only on generator a, generator b and mains, full mode
    for (int s = 0; s < 3; s++) begin
      wb(1'b1, 8'h00, s | 32'h104);
      wait_hi(0, 3000);
      chk(SYNC_ERR_O, 1'b0);
      // index of a every 384 ns, of b and mains crossings every 768 ns
      wb(1'b0, 8'h1C, 32'h0);
      chk(q, (s == 0) ? 32'h60 : 32'hC0);
      wb(1'b1, 8'h00, 32'h200);
    end
    // clock plus index on generator a in full, timed and measured modes
    for (int m = 0; m < 3; m++) begin
      wb(1'b1, 8'h00, (m << 4) | 32'h100);
      wait_hi(0, 3000);
      wb(1'b0, 8'h14, 32'h0);
      chk(q[4], m != 2);
      n = 0;
      repeat (192) begin
        @(posedge MCLK_I);
        if (ZERO_DEG_O === 1'b1) n++;
      end
      chk(n, 2);
      wb(1'b0, 8'h18, 32'h0);
      chk(q, 32'h8);
      repeat (300) @(posedge MCLK_I);
      wb(1'b0, 8'h14, 32'h0);
      chk(q[4], m == 0);
      chk(SYNC_ERR_O, 1'b0);
      wb(1'b1, 8'h00, 32'h200);
    end
    wb(1'b1, 8'h04, 32'h7);
    wb(1'b1, 8'h00, 32'h100);
    wait_hi(1, 3000);
    chk(RUNNING_O, 1'b0);
    wb(1'b1, 8'h00, 32'h200);
    wb(1'b0, 8'h20, 32'h0);
    chk(q, 32'h1);
    wb(1'b1, 8'h20, 32'h3);
    wb(1'b0, 8'h20, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, 8'h04, 32'h8);
    wb(1'b1, 8'h08, 32'h4E20);
    wb(1'b1, 8'h0C, 32'h200);
    wb(1'b1, 8'h00, 32'h104);
    wait_hi(1, 3000);
    wb(1'b1, 8'h00, 32'h200);
    wb(1'b0, 8'h20, 32'h0);
    chk(q, 32'h2);
    close_out();
  end
endmodule
